//--- hdl/agts_pkg.sv
// Constants, types and state layout of the GCM tag sequencer.
// Assumes one 20 MHz clock, a simple strobe register port and an external
// single-block cipher engine on the same clock.
// Notes on behaviour
// - The tag is the cipher of the pre-counter block xored with the hash after the length block.
// - With auto tagging on, the tag follows the end of AAD and text by itself; otherwise software uses the hash.
// - Writing a key makes the engine derive the hash subkey and then raise data ready, which can interrupt.
// - Once the subkey is ready software may read it or overwrite it, and the written value is used.
// - Data ready is raised each time a written input block, AAD included, has been processed.
// - AAD blocks give no output data and only enter the hash.
// - When the auto tag is complete, tag ready is raised, can interrupt, and the tag registers hold it.
// - With auto tagging off, the running hash stays readable in the hash value registers.
package agts_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CLK_HZ = 20_000_000;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_AAD_LEN = 8'h10;
  localparam logic [7:0] REG_TEXT_LEN = 8'h14;
  localparam logic [3:0] GRP_KEY = 4'h2;
  localparam logic [3:0] GRP_IV = 4'h3;
  localparam logic [3:0] GRP_DIN = 4'h4;
  localparam logic [3:0] GRP_DOUT = 4'h5;
  localparam logic [3:0] GRP_HSUB = 4'h6;
  localparam logic [3:0] GRP_HASH = 4'h7;
  localparam logic [3:0] GRP_TAG = 4'h8;

  // Field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned MODE_OP_LSB = 0;
  localparam int unsigned MODE_DECRYPT_BIT = 4;
  localparam int unsigned MODE_START_MODE_SELECT_BIT = 8;
  localparam int unsigned MODE_AUTOTAG_BIT = 16;
  localparam int unsigned ST_DATA_READY_BIT = 0;
  localparam int unsigned ST_TAG_READY_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 8;

  // Mode encodings and reset values
  localparam logic [2:0] OPMODE_ECB = 3'h0;
  localparam logic [2:0] OPMODE_GCM = 3'h5;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [31:0] LEN_RST = 32'h0;
  localparam logic [127:0] BLK_RST = 128'h0;
  localparam logic [127:0] GF_POLY = {8'he1, 120'h0};
  localparam logic [6:0] MUL_LAST = 7'h7f;
  localparam logic [31:0] BLK_BYTES = 32'h10;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_KEY_WAIT,
    ST_BLK_WAIT,
    ST_MULT,
    ST_TAG_WAIT
  } agts_st_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } agts_bus_req_s;

  typedef struct packed {
    logic start;
    logic [127:0] key;
    logic [127:0] blk;
  } agts_eng_req_s;

  typedef struct packed {
    agts_st_e st;
    logic [2:0] opmode;
    logic decrypt;
    logic start_mode_select_auto;
    logic auto_tag;
    logic sub_ok;
    logic len_pass;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [31:0] aad_len;
    logic [31:0] text_len;
    logic [31:0] aad_left;
    logic [31:0] text_left;
    logic [31:0] cur_bytes;
    logic [127:0] iv;
    logic [127:0] ctr;
    logic [127:0] hsub;
    logic [127:0] hash;
    logic [127:0] din;
    logic [127:0] dout;
    logic [127:0] tag;
    logic [127:0] mz;
    logic [127:0] mv;
    logic [127:0] my;
    logic [6:0] mcnt;
    logic [31:0] rdata;
    logic irq;
    agts_eng_req_s eng;
  } agts_state_s;

endpackage

//--- hdl/agts_top.sv
// GCM sequencer: subkey setup, counter blocks, HASH_VALUE_FIELD, length block and tag.
// Assumes a register master on i_clk and a block cipher engine that answers
// a start pulse with a one-cycle done pulse and its result, same clock.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module agts_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input agts_pkg::agts_bus_req_s i_bus,
  output logic [31:0] o_rdata,
  // Cipher engine
  output agts_pkg::agts_eng_req_s o_eng,
  input wire logic i_eng_done,
  input wire logic [127:0] i_eng_result,
  // Interrupt
  output logic o_irq
);
  import agts_pkg::*;

  agts_state_s s_q;
  agts_state_s s_d;

  // Top n bytes of a block kept, the rest cleared
  function automatic logic [127:0] byte_mask(input logic [31:0] n);
    logic [127:0] m;
    m = BLK_RST;
    for (int i = 0; i < 16; i++) begin
      if (32'(i) < n) begin
        m[127-8*i -: 8] = 8'hff;
      end
    end
    return m;
  endfunction

  // Word k of a block, word 0 being the most significant
  function automatic logic [31:0] get_word(input logic [127:0] b, input logic [1:0] k);
    return b[(3-int'(k))*32 +: 32];
  endfunction

  function automatic logic [127:0] put_word(input logic [127:0] b, input logic [1:0] k,
                                            input logic [31:0] w);
    logic [127:0] r;
    r = b;
    r[(3-int'(k))*32 +: 32] = w;
    return r;
  endfunction

  function automatic logic [31:0] min16(input logic [31:0] n);
    return (n > BLK_BYTES) ? BLK_BYTES : n;
  endfunction

  logic busy;
  logic [3:0] grp;
  logic [1:0] widx;
  logic wr_ok;
  logic start_req;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [127:0] z_next;
  logic [127:0] v_next;
  logic [127:0] ctext;
  logic [127:0] len_blk;
  logic [127:0] j0;

  assign busy = (s_q.st != ST_IDLE);
  assign grp = i_bus.addr[7:4];
  assign widx = i_bus.addr[3:2];
  assign wr_ok = i_bus.wr && !busy;

  // GF(2^128) multiplier step, one bit of the subkey per cycle
  assign z_next = s_q.my[127] ? (s_q.mz ^ s_q.mv) : s_q.mz;
  assign v_next = s_q.mv[0] ? ((s_q.mv >> 1) ^ GF_POLY) : (s_q.mv >> 1);

  // Length block in bits, then the pre-counter block from the loaded IV
  assign len_blk = {29'h0, s_q.aad_len, 3'h0, 29'h0, s_q.text_len, 3'h0};
  assign j0 = {s_q.iv[127:32], s_q.iv[31:0] - 32'h1};

  // Block to hash: the ciphertext side of the text
  assign ctext = s_q.decrypt ? s_q.din : (s_q.din ^ i_eng_result);

  // A block starts by control write or by the last input word in auto mode
  always_comb begin
    start_req = 1'b0;
    if (wr_ok && s_q.sub_ok) begin
      if (s_q.start_mode_select_auto) begin
        start_req = (grp == GRP_DIN) && (widx == 2'h3);
      end else begin
        start_req = (i_bus.addr == REG_CTRL) && i_bus.wdata[CTRL_START_BIT];
      end
    end
  end

  // Write one to clear status flags
  always_comb begin
    flag_clr = 2'h0;
    if (i_bus.wr && (i_bus.addr == REG_STATUS)) begin
      flag_clr = {i_bus.wdata[ST_TAG_READY_BIT], i_bus.wdata[ST_DATA_READY_BIT]};
    end
  end

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    flag_set = 2'h0;
    s_d.eng.start = 1'b0;

    // Configuration writes, taken only while idle
    if (wr_ok) begin
      if (i_bus.addr == REG_MODE) begin
        s_d.opmode = i_bus.wdata[MODE_OP_LSB +: 3];
        s_d.decrypt = i_bus.wdata[MODE_DECRYPT_BIT];
        s_d.start_mode_select_auto = i_bus.wdata[MODE_START_MODE_SELECT_BIT];
        s_d.auto_tag = i_bus.wdata[MODE_AUTOTAG_BIT];
      end
      if (i_bus.addr == REG_AAD_LEN) begin
        s_d.aad_len = i_bus.wdata;
        s_d.aad_left = i_bus.wdata;
      end
      if (i_bus.addr == REG_TEXT_LEN) begin
        s_d.text_len = i_bus.wdata;
        s_d.text_left = i_bus.wdata;
      end
      if (i_bus.addr == REG_MASK) begin
        s_d.mask = {i_bus.wdata[ST_TAG_READY_BIT], i_bus.wdata[ST_DATA_READY_BIT]};
      end
      unique case (grp)
        GRP_KEY: s_d.eng.key = put_word(s_q.eng.key, widx, i_bus.wdata);
        GRP_IV: begin
          s_d.iv = put_word(s_q.iv, widx, i_bus.wdata);
          s_d.ctr = put_word(s_q.iv, widx, i_bus.wdata);
        end
        GRP_DIN: s_d.din = put_word(s_q.din, widx, i_bus.wdata);
        GRP_HSUB: begin
          if (s_q.sub_ok) begin
            s_d.hsub = put_word(s_q.hsub, widx, i_bus.wdata);
          end
        end
        GRP_HASH: s_d.hash = put_word(s_q.hash, widx, i_bus.wdata);
        default: ;
      endcase
      // Last key word launches subkey generation from the zero block
      if ((grp == GRP_KEY) && (widx == 2'h3)) begin
        s_d.sub_ok = 1'b0;
        s_d.hash = BLK_RST;
        s_d.eng.blk = BLK_RST;
        s_d.eng.start = 1'b1;
        s_d.st = ST_KEY_WAIT;
      end
    end

    unique case (s_q.st)
      ST_IDLE: begin
        if (start_req) begin
          s_d.len_pass = 1'b0;
          // Next-state input block, so a word 3 that starts in auto mode is included
          if (s_q.opmode != OPMODE_GCM) begin
            s_d.eng.blk = s_d.din;
            s_d.eng.start = 1'b1;
            s_d.st = ST_BLK_WAIT;
          end else if (s_q.aad_left != LEN_RST) begin
            // AAD goes only into the hash, no cipher pass
            s_d.cur_bytes = min16(s_q.aad_left);
            s_d.aad_left = s_q.aad_left - min16(s_q.aad_left);
            s_d.mv = s_q.hash ^ (s_d.din & byte_mask(min16(s_q.aad_left)));
            s_d.mz = BLK_RST;
            s_d.my = s_q.hsub;
            s_d.mcnt = 7'h0;
            s_d.st = ST_MULT;
          end else begin
            s_d.cur_bytes = min16(s_q.text_left);
            s_d.eng.blk = s_q.ctr;
            s_d.eng.start = 1'b1;
            s_d.st = ST_BLK_WAIT;
          end
        end
      end
      ST_KEY_WAIT: begin
        if (i_eng_done) begin
          s_d.hsub = i_eng_result;
          s_d.sub_ok = 1'b1;
          flag_set[ST_DATA_READY_BIT] = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      ST_BLK_WAIT: begin
        if (i_eng_done) begin
          if (s_q.opmode != OPMODE_GCM) begin
            s_d.dout = i_eng_result;
            flag_set[ST_DATA_READY_BIT] = 1'b1;
            s_d.st = ST_IDLE;
          end else begin
            // Counter text block: output, advance counter, hash ciphertext
            s_d.dout = (s_q.din ^ i_eng_result) & byte_mask(s_q.cur_bytes);
            s_d.ctr = {s_q.ctr[127:32], s_q.ctr[31:0] + 32'h1};
            s_d.text_left = s_q.text_left - s_q.cur_bytes;
            s_d.mv = s_q.hash ^ (ctext & byte_mask(s_q.cur_bytes));
            s_d.mz = BLK_RST;
            s_d.my = s_q.hsub;
            s_d.mcnt = 7'h0;
            s_d.st = ST_MULT;
          end
        end
      end
      ST_MULT: begin
        s_d.mz = z_next;
        s_d.mv = v_next;
        s_d.my = {s_q.my[126:0], 1'b0};
        s_d.mcnt = s_q.mcnt + 7'h1;
        if (s_q.mcnt == MUL_LAST) begin
          s_d.hash = z_next;
          if (s_q.len_pass) begin
            // Hash of lengths done, cipher the pre-counter block
            s_d.eng.blk = j0;
            s_d.eng.start = 1'b1;
            s_d.st = ST_TAG_WAIT;
          end else begin
            flag_set[ST_DATA_READY_BIT] = 1'b1;
            if (s_q.auto_tag && (s_q.aad_left == LEN_RST) && (s_q.text_left == LEN_RST)) begin
              s_d.len_pass = 1'b1;
              s_d.mv = z_next ^ len_blk;
              s_d.mz = BLK_RST;
              s_d.my = s_q.hsub;
              s_d.mcnt = 7'h0;
              s_d.st = ST_MULT;
            end else begin
              s_d.st = ST_IDLE;
            end
          end
        end
      end
      ST_TAG_WAIT: begin
        if (i_eng_done) begin
          s_d.tag = i_eng_result ^ s_q.hash;
          s_d.len_pass = 1'b0;
          flag_set[ST_TAG_READY_BIT] = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
    endcase

    // Set wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~flag_clr) | flag_set;
    s_d.irq = |(s_d.flags & s_d.mask);

    // Read data stand in the cycle after the strobe
    s_d.rdata = 32'h0;
    if (i_bus.rd) begin
      if (i_bus.addr == REG_MODE) begin
        s_d.rdata[MODE_OP_LSB +: 3] = s_q.opmode;
        s_d.rdata[MODE_DECRYPT_BIT] = s_q.decrypt;
        s_d.rdata[MODE_START_MODE_SELECT_BIT] = s_q.start_mode_select_auto;
        s_d.rdata[MODE_AUTOTAG_BIT] = s_q.auto_tag;
      end else if (i_bus.addr == REG_STATUS) begin
        s_d.rdata[ST_DATA_READY_BIT] = s_q.flags[ST_DATA_READY_BIT];
        s_d.rdata[ST_TAG_READY_BIT] = s_q.flags[ST_TAG_READY_BIT];
        s_d.rdata[ST_BUSY_BIT] = busy;
      end else if (i_bus.addr == REG_MASK) begin
        s_d.rdata[ST_DATA_READY_BIT] = s_q.mask[ST_DATA_READY_BIT];
        s_d.rdata[ST_TAG_READY_BIT] = s_q.mask[ST_TAG_READY_BIT];
      end else if (i_bus.addr == REG_AAD_LEN) begin
        s_d.rdata = s_q.aad_len;
      end else if (i_bus.addr == REG_TEXT_LEN) begin
        s_d.rdata = s_q.text_len;
      end else begin
        unique case (grp)
          GRP_IV: s_d.rdata = get_word(s_q.iv, widx);
          GRP_DOUT: s_d.rdata = get_word(s_q.dout, widx);
          GRP_HSUB: s_d.rdata = s_q.sub_ok ? get_word(s_q.hsub, widx) : 32'h0;
          GRP_HASH: s_d.rdata = get_word(s_q.hash, widx);
          GRP_TAG: s_d.rdata = get_word(s_q.tag, widx);
          default: s_d.rdata = 32'h0;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '{st: ST_IDLE, opmode: OPMODE_ECB, decrypt: 1'b0, start_mode_select_auto: 1'b0,
               auto_tag: 1'b0, sub_ok: 1'b0, len_pass: 1'b0, flags: FLAGS_RST,
               mask: MASK_RST, aad_len: LEN_RST, text_len: LEN_RST, aad_left: LEN_RST,
               text_left: LEN_RST, cur_bytes: LEN_RST, iv: BLK_RST, ctr: BLK_RST,
               hsub: BLK_RST, hash: BLK_RST, din: BLK_RST, dout: BLK_RST, tag: BLK_RST,
               mz: BLK_RST, mv: BLK_RST, my: BLK_RST, mcnt: 7'h0, rdata: 32'h0, irq: 1'b0,
               eng: '{start: 1'b0, key: BLK_RST, blk: BLK_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign o_rdata = s_q.rdata;
  assign o_eng = s_q.eng;
  assign o_irq = s_q.irq;

endmodule

//--- dv/agts_top_properties.sv
// Port checker for agts_top: read data, engine handshake, interrupt gating.
// Assumes it is bound to agts_top and sees only the top module's ports.
`timescale 1ns/100ps
module agts_top_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Watched ports
  input agts_pkg::agts_bus_req_s i_bus,
  input wire logic [31:0] o_rdata,
  input agts_pkg::agts_eng_req_s o_eng,
  input wire logic i_eng_done,
  input wire logic o_irq
);
  import agts_pkg::*;
  logic pend_q;
  logic mask_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Tracks an outstanding engine request and whether a mask bit was ever set
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_q <= 1'b0;
      mask_q <= 1'b0;
    end else begin
      pend_q <= o_eng.start | (pend_q & ~i_eng_done);
      mask_q <= mask_q | (i_bus.wr && i_bus.addr == REG_MASK && i_bus.wdata[1:0] != 2'h0);
    end
  end
  AST_RDATA_IDLE: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  AST_KEY_WO: assert property ($past(i_bus.rd && i_bus.addr[7:4] == GRP_KEY) |-> o_rdata == 32'h0)
    else $error("key words readable");
  AST_CTRL_RD: assert property ($past(i_bus.rd && i_bus.addr == REG_CTRL) |-> o_rdata == 32'h0)
    else $error("control register not read as zero");
  AST_UNMAPPED: assert property ($past(i_bus.rd && i_bus.addr[7:4] > GRP_TAG) |-> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_START_PULSE: assert property (o_eng.start |=> !o_eng.start)
    else $error("engine start longer than one cycle");
  AST_ONE_OUT: assert property (pend_q && !i_eng_done |-> !o_eng.start)
    else $error("second engine request while one is open");
  AST_BLK_HOLD: assert property (pend_q |-> $stable(o_eng.blk) && $stable(o_eng.key))
    else $error("engine block or key moved while waiting");
  AST_IRQ_MASK: assert property (!mask_q |-> !o_irq)
    else $error("interrupt without any mask bit");
  AST_KEY_START: assert property (i_bus.wr && i_bus.addr == 8'h2c && !pend_q
    |=> o_eng.start && o_eng.blk == BLK_RST)
    else $error("key write did not start subkey generation");
  COV_DONE: cover property (i_eng_done);
  COV_IRQ: cover property ($rose(o_irq));
  COV_READ: cover property ($past(i_bus.rd) && o_rdata != 32'h0);
endmodule
bind agts_top agts_top_properties agts_top_properties_i (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_bus(i_bus), .o_rdata(o_rdata), .o_eng(o_eng), .i_eng_done(i_eng_done), .o_irq(o_irq));

//--- dv/test_aes_gcm_tag_sequencer.sv
// Self-checking bench for agts_top: register table, auto tag, manual hash.
// Assumes the bench itself stands in for the cipher engine (result = blk ^ key).
`timescale 1ns/100ps
module test_aes_gcm_tag_sequencer;
  import agts_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} agts_row_s;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  agts_bus_req_s i_bus = '0;
  logic [31:0] o_rdata;
  agts_eng_req_s o_eng;
  logic i_eng_done = 1'b0;
  logic [127:0] i_eng_result = '0;
  logic o_irq;
  int errors = 0;
  int checks_done = 0;
  int starts = 0;
  int dly = 0;
  logic [31:0] rv;
  logic [127:0] bv;
  localparam logic [127:0] K1 = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;
  localparam logic [127:0] K2 = 128'h11223344_55667788_99aabbcc_ddeeff00;
  localparam logic [127:0] H2 = 128'h66e94bd4_ef8a2c3b_884cfa59_ca342b2e;
  localparam logic [127:0] J0 = 128'hcafebabe_facedbad_decaf888_00000001;
  localparam logic [127:0] A1 = 128'hfeedface_deadbeef_feedface_deadbeef;
  localparam logic [127:0] P1 = 128'hd9313225_f88406e5_a55909c5_aff5269a;
  agts_row_s rows [12] = '{'{REG_MODE, 32'h0001_0115, 32'h0001_0115},
    '{REG_MASK, 32'h3, 32'h3}, '{REG_AAD_LEN, 32'h20, 32'h20}, '{REG_TEXT_LEN, 32'h21, 32'h21},
    '{8'h3c, 32'h1234_5678, 32'h1234_5678}, '{REG_CTRL, 32'h0, 32'h0}, '{8'h70, 32'h1, 32'h1},
    '{8'h20, 32'hdead_beef, 32'h0}, '{8'h60, 32'h5555_aaaa, 32'h0}, '{8'h40, 32'h77, 32'h0},
    '{8'hf0, 32'hffff_ffff, 32'h0}, '{REG_STATUS, 32'h3, 32'h0}};
  agts_top agts_top_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_eng(o_eng), .i_eng_done(i_eng_done), .i_eng_result(i_eng_result), .o_irq(o_irq));
  // Engine stand-in: done rises four cycles after start rises; result toggles outside done
  always @(posedge i_clk) begin
    i_eng_done <= 1'b0;
    i_eng_result <= ~i_eng_result;
    if (o_eng.start === 1'b1) begin
      dly <= 3;
      starts <= starts + 1;
    end else if (dly != 0) begin
      dly <= dly - 1;
      if (dly == 1) begin
        i_eng_done <= 1'b1;
        i_eng_result <= o_eng.blk ^ o_eng.key;
      end
    end
  end
  // Clock at 20 MHz
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  // Multiply in the GCM field, bit 127 first
  function automatic logic [127:0] gf(input logic [127:0] x, input logic [127:0] y);
    logic [127:0] z;
    logic [127:0] v;
    z = '0;
    v = y;
    for (int i = 127; i >= 0; i--) begin
      if (x[i]) z = z ^ v;
      v = v[0] ? (v >> 1) ^ GF_POLY : v >> 1;
    end
    return z;
  endfunction
  task automatic chk(input logic [127:0] g, input logic [127:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t %s got %h", $time, m, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    i_bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    i_bus.rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wblk(input logic [3:0] g, input logic [127:0] b);
    for (int i = 0; i < 4; i++) wr({g, 4'(4 * i)}, b[127 - 32 * i -: 32]);
  endtask
  task automatic rblk(input logic [3:0] g, output logic [127:0] b);
    for (int i = 0; i < 4; i++) begin
      rd({g, 4'(4 * i)}, rv);
      b[127 - 32 * i -: 32] = rv;
    end
  endtask
  task automatic wait_st(input int b);
    for (int n = 0; n < 1000; n++) begin
      rd(REG_STATUS, rv);
      if (rv[b] === 1'b1) return;
    end
    chk(1'b0, 1'b1, "status flag never set");
  endtask
  task automatic go(input logic [127:0] d);
    wblk(GRP_DIN, d);
    wr(REG_CTRL, 32'h1);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(50 * 60000);
    errors++;
    complete_run();
  end
  initial begin
    logic [127:0] c1;
    int s0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1 chk(o_irq, 1'b0, "irq after reset");
    // Reset value, then write and read back, per row
    foreach (rows[i]) begin
      rd(rows[i].a, rv);
      chk(rv, 32'h0, "reset value");
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rv);
      chk(rv, rows[i].e, "register access");
    end
    // Auto tag over one AAD block and one text block
    wr(REG_MODE, 32'h0001_0005);
    wblk(GRP_KEY, K1);
    wait_st(ST_DATA_READY_BIT);
    chk(o_irq, 1'b1, "irq on subkey");
    rblk(GRP_HSUB, bv);
    chk(bv, K1, "subkey read");
    wr(REG_STATUS, 32'h3);
    rd(REG_STATUS, rv);
    chk(o_irq, 1'b0, "irq after clear");
    wblk(GRP_IV, J0 + 128'h1);
    wr(REG_AAD_LEN, 32'h10);
    wr(REG_TEXT_LEN, 32'h10);
    s0 = starts;
    go(A1);
    wait_st(ST_DATA_READY_BIT);
    chk(128'(starts - s0), 128'h0, "AAD block ciphered");
    wr(REG_STATUS, 32'h1);
    go(P1);
    wait_st(ST_DATA_READY_BIT);
    c1 = P1 ^ (J0 + 128'h1) ^ K1;
    rblk(GRP_DOUT, bv);
    chk(bv, c1, "text out");
    wait_st(ST_TAG_READY_BIT);
    rblk(GRP_TAG, bv);
    chk(bv, gf(gf(gf(A1, K1) ^ c1, K1) ^ {64'd128, 64'd128}, K1) ^ J0 ^ K1, "tag");
    // Manual hash with a chosen subkey
    wr(REG_STATUS, 32'h3);
    wr(REG_MODE, 32'h5);
    wblk(GRP_KEY, K2);
    wait_st(ST_DATA_READY_BIT);
    wr(REG_STATUS, 32'h1);
    wblk(GRP_HSUB, H2);
    wblk(GRP_IV, J0 + 128'h1);
    wr(REG_AAD_LEN, 32'h0);
    wr(REG_TEXT_LEN, 32'h10);
    go(P1);
    wait_st(ST_DATA_READY_BIT);
    rblk(GRP_HASH, bv);
    chk(bv, gf(P1 ^ (J0 + 128'h1) ^ K2, H2), "manual hash");
    rd(REG_STATUS, rv);
    chk(rv[ST_TAG_READY_BIT], 1'b0, "tag without auto");
    // Direct cipher mode, started by the last input word in auto start mode
    wr(REG_STATUS, 32'h1);
    wr(REG_MODE, 32'h100);
    s0 = starts;
    wblk(GRP_DIN, P1);
    wait_st(ST_DATA_READY_BIT);
    chk(128'(starts - s0), 128'h1, "auto start count");
    rblk(GRP_DOUT, bv);
    chk(bv, P1 ^ K2, "direct cipher out");
    wr(REG_STATUS, 32'h1);
    // Reset in mid-block
    go(P1);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(REG_MODE, rv);
    chk(rv, 32'h0, "mode after reset");
    rblk(GRP_HSUB, bv);
    chk(bv, 128'h0, "subkey after reset");
    complete_run();
  end
endmodule
